// ==== core/rws_reset_wake.sv ====
// Reset source and wake-up bookkeeping with AHB-Lite register slave.
// Assumes one 10 MHz clock; analog conditions and pins arrive asynchronously,
// watchdog request and mode levels come from logic on hclk.
`timescale 1ns/1ps
`default_nettype none
module rws_reset_wake #(
  parameter int RST_PULSE_CYC = rws_pkg::RST_PULSE_CYC
) (
  // Clock and reset
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  // AHB-Lite slave
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Asynchronous conditions and pins
  input  wire  logic        overtemp_in,
  input  wire  logic        low_voltage_in,
  input  wire  logic        power_on_in,
  input  wire  logic        rst_pin_in,
  input  wire  logic        lin_rx_in,
  input  wire  logic        l0_in,
  // Same-clock controls
  input  wire  logic        watchdog_req,
  input  wire  logic        stop_mode,
  input  wire  logic        sleep_mode,
  // Reset pin (open drain) and system outputs
  output logic              rst_pin_out,
  output logic              rst_pin_oe,
  output logic              regs_rst_n,
  output logic              lin_tx_enable,
  output logic              lin_pullup_enable,
  output logic              system_wake,
  output logic              irq
);

  // ==========================================================================
  // Input synchronisers
  logic [rws_pkg::NSYNC-1:0] async_in;
  logic [rws_pkg::NSYNC-1:0] sync1;
  logic [rws_pkg::NSYNC-1:0] sync2;

  assign async_in = {overtemp_in, low_voltage_in, power_on_in,
                     rst_pin_in, lin_rx_in, l0_in};

  // Two stages per pin; only the second stage feeds logic
  genvar gi;
  generate
    for (gi = 0; gi < rws_pkg::NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          sync1[gi] <= rws_pkg::SYNC_RST_VAL[gi];
          sync2[gi] <= rws_pkg::SYNC_RST_VAL[gi];
        end
        else
        begin
          sync1[gi] <= async_in[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic ot_s, lv_s, por_s, pin_s, rx_s, l0_s;
  assign {ot_s, lv_s, por_s, pin_s, rx_s, l0_s} = sync2;

  // ==========================================================================
  // Bus front end
  logic       acc;
  logic       wr_ph;
  logic       rd_wait;
  logic [5:0] a_idx;
  logic [7:0] reset_source_status;
  logic [7:0] imr;
  logic [7:0] ifr;

  // Word index match, shared by write and read decode
  function automatic logic hit(input logic [5:0] idx, input logic [5:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction

  assign acc       = hsel & hready & htrans[1];
  // One wait state on reads so read data always reflects completed writes
  assign hreadyout = ~rd_wait;
  assign hresp     = 1'b0;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph   <= 1'b0;
      rd_wait <= 1'b0;
      a_idx   <= 6'h00;
    end
    else
    begin
      wr_ph   <= acc & hwrite;
      rd_wait <= acc & ~hwrite;
      if (acc)
      begin
        a_idx <= haddr[7:2];
      end
    end
  end

  logic wr_rsr, wr_imr, wr_ifr;
  assign wr_rsr = wr_ph & hit(a_idx, rws_pkg::IDX_RSR);
  assign wr_imr = wr_ph & hit(a_idx, rws_pkg::IDX_IMR);
  assign wr_ifr = wr_ph & hit(a_idx, rws_pkg::IDX_IFR);

  // Read data loaded in the wait cycle; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_wait)
    begin
      if (hit(a_idx, rws_pkg::IDX_RSR))
      begin
        hrdata <= {24'h00_0000, reset_source_status};
      end
      else if (hit(a_idx, rws_pkg::IDX_IMR))
      begin
        hrdata <= {24'h00_0000, imr};
      end
      else if (hit(a_idx, rws_pkg::IDX_IFR))
      begin
        hrdata <= {24'h00_0000, ifr};
      end
      else
      begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Reset causes and pulse stretcher
  logic                         ot_cause;
  logic                         int_cause;
  logic                         wake_rst;
  logic                         ext_low;
  logic                         clr;
  logic [rws_pkg::RST_CNT_W-1:0] rst_cnt;
  logic [1:0]                   oe_hist;

  // Test-only disable; default clear keeps the part protected
  assign ot_cause  = ot_s & ~imr[rws_pkg::IMR_OTRD];
  assign int_cause = ot_cause | lv_s | por_s | watchdog_req | wake_rst;
  // Ignore the pin for two cycles after our own release: synchroniser lag
  assign ext_low   = ~pin_s & ~rst_pin_oe & ~oe_hist[0] & ~oe_hist[1];
  assign clr       = int_cause | rst_pin_oe | ext_low;
  assign rst_pin_out = 1'b0;

  // Counter reloads while a cause is present, runs down after it leaves
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rst_cnt <= '0;
    end
    else if (int_cause)
    begin
      rst_cnt <= rws_pkg::RST_CNT_W'(RST_PULSE_CYC);
    end
    else if (rst_cnt != '0)
    begin
      rst_cnt <= rst_cnt - 1'b1;
    end
  end

  // Pin drive and register reset request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rst_pin_oe <= 1'b1;
      oe_hist    <= 2'b11;
      regs_rst_n <= 1'b0;
    end
    else
    begin
      rst_pin_oe <= int_cause | (rst_cnt != '0);
      oe_hist    <= {oe_hist[0], rst_pin_oe};
      regs_rst_n <= ~clr;
    end
  end

  // ==========================================================================
  // LIN wake filter (dominant longer than filter, then rising edge)
  rws_pkg::rws_wf_t               wf_state;
  logic [rws_pkg::WAKE_CNT_W-1:0] dom_cnt;
  logic                           lp;
  logic                           lin_evt;
  logic                           l0_ref;
  logic [2:0]                     l0_arm;
  logic                           l0_evt;

  assign lp      = stop_mode | sleep_mode;
  assign lin_evt = lp & rx_s & (wf_state == rws_pkg::WF_ARMED);
  // No edge until the synchronised level is real, whatever the pin idles at
  assign l0_evt  = l0_arm[2] & (l0_s ^ l0_ref);

  // Receiver stays alive in low power; filter only runs there
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wf_state <= rws_pkg::WF_IDLE;
      dom_cnt  <= '0;
    end
    else
    begin
      case (wf_state)
        rws_pkg::WF_IDLE:
        begin
          dom_cnt <= rws_pkg::WAKE_CNT_W'(1);
          if (lp && !rx_s)
          begin
            wf_state <= rws_pkg::WF_DOM;
          end
        end
        rws_pkg::WF_DOM:
        begin
          if (!lp || rx_s)
          begin
            wf_state <= rws_pkg::WF_IDLE;
          end
          else if (dom_cnt == rws_pkg::WAKE_CNT_W'(rws_pkg::WAKE_FILTER_CYC))
          begin
            wf_state <= rws_pkg::WF_ARMED;
          end
          else
          begin
            dom_cnt <= dom_cnt + 1'b1;
          end
        end
        rws_pkg::WF_ARMED:
        begin
          if (!lp || rx_s)
          begin
            wf_state <= rws_pkg::WF_IDLE;
          end
        end
        default:
        begin
          wf_state <= rws_pkg::WF_IDLE;
        end
      endcase
    end
  end

  // L0 reference follows the pin each cycle, so l0_evt flags every L0 edge, whatever the mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      l0_ref <= 1'b0;
      l0_arm <= 3'h0;
    end
    else
    begin
      l0_ref <= l0_s;
      l0_arm <= {l0_arm[1:0], 1'b1};
    end
  end

  // Wake outputs and transmitter control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_rst          <= 1'b0;
      system_wake       <= 1'b0;
      lin_tx_enable     <= 1'b0;
      lin_pullup_enable <= 1'b0;
    end
    else
    begin
      wake_rst          <= sleep_mode & (lin_evt | l0_evt);
      system_wake       <= (sleep_mode & (lin_evt | l0_evt))
                         | (stop_mode & lin_evt & imr[rws_pkg::IMR_LIN_INTERRUPT_ENABLE])
                         | (stop_mode & l0_evt & imr[rws_pkg::IMR_L0IE]);
      lin_tx_enable     <= ~lp;
      lin_pullup_enable <= ~lp;
    end
  end

  // ==========================================================================
  // Reset source status: survives all resets except power-on
  logic [7:0] rsr_set;
  logic [7:0] rsr_clr;

  always_comb
  begin
    rsr_set                    = 8'h00;
    rsr_set[rws_pkg::RSR_PIN]  = ext_low;
    rsr_set[rws_pkg::RSR_WD]   = watchdog_req;
    rsr_set[rws_pkg::RSR_OT]   = ot_cause;
    rsr_set[rws_pkg::RSR_LV]   = lv_s;
    rsr_set[rws_pkg::RSR_LINW] = sleep_mode & lin_evt;
    rsr_set[rws_pkg::RSR_L0W]  = sleep_mode & l0_evt;
    rsr_clr = wr_rsr ? (hwdata[7:0] & rws_pkg::RSR_W1C) : 8'h00;
  end

  // Power-on overrides everything; otherwise set beats clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reset_source_status <= rws_pkg::RSR_POR_VAL;
    end
    else if (por_s)
    begin
      reset_source_status <= rws_pkg::RSR_POR_VAL;
    end
    else
    begin
      reset_source_status <= (reset_source_status & ~rsr_clr) | rsr_set;
    end
  end

  // ==========================================================================
  // Interrupt mask and flags, cleared by any internal reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      imr <= rws_pkg::IMR_RST_VAL;
    end
    else if (clr)
    begin
      imr <= rws_pkg::IMR_RST_VAL;
    end
    else if (wr_imr)
    begin
      imr <= hwdata[7:0] & rws_pkg::IMR_WMASK;
    end
  end

  logic [7:0] ifr_set;
  assign ifr_set = {~sleep_mode & l0_evt, 1'b0,
                    stop_mode & ~sleep_mode & lin_evt & imr[rws_pkg::IMR_LIN_INTERRUPT_ENABLE],
                    5'h00};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ifr <= rws_pkg::IFR_RST_VAL;
      irq <= 1'b0;
    end
    else
    begin
      if (clr)
      begin
        ifr <= rws_pkg::IFR_RST_VAL;
      end
      else
      begin
        ifr <= (ifr & ~(wr_ifr ? (hwdata[7:0] & rws_pkg::IFR_MASK) : 8'h00)) | ifr_set;
      end
      irq <= |(ifr & imr & rws_pkg::IFR_MASK);
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ot_flag_a: assert property ((ot_cause && !por_s) |=> reset_source_status[rws_pkg::RSR_OT] && rst_pin_oe)
    else $error("over-temperature did not reset and flag");
  ot_disable_a: assert property ((ot_s && imr[rws_pkg::IMR_OTRD] && !lv_s && !por_s &&
      !watchdog_req && !wake_rst && rst_cnt == '0 && !ext_low) |=> !rst_pin_oe)
    else $error("disabled over-temperature still drove reset");
  wd_flag_a: assert property ((watchdog_req && !por_s) |=> reset_source_status[rws_pkg::RSR_WD] && !regs_rst_n)
    else $error("watchdog reset not flagged");
  lv_pin_a: assert property ((lv_s && !por_s) |=> rst_pin_oe && reset_source_status[rws_pkg::RSR_LV])
    else $error("low voltage did not drive pin");
  por_value_a: assert property (por_s |=> reset_source_status == rws_pkg::RSR_POR_VAL)
    else $error("power-on left wrong status");
  pulse_hold_a: assert property ($fell(int_cause) |-> rst_pin_oe [*8])
    else $error("reset pin released early");
  ext_flag_a: assert property (ext_low && !por_s |=> reset_source_status[rws_pkg::RSR_PIN])
    else $error("external reset not flagged");
  keep_bits_a: assert property ((wr_rsr && !por_s) |=>
      ((reset_source_status & $past(reset_source_status) & ~$past(hwdata[7:0])) == ($past(reset_source_status) & ~$past(hwdata[7:0]))))
    else $error("status bit lost without a one written");
  set_wins_a: assert property ((watchdog_req && wr_rsr && hwdata[rws_pkg::RSR_WD] && !por_s)
      |=> reset_source_status[rws_pkg::RSR_WD])
    else $error("clear beat a new event");
  lin_stop_a: assert property ((lin_evt && stop_mode && !sleep_mode &&
      imr[rws_pkg::IMR_LIN_INTERRUPT_ENABLE] && !clr) |=> ifr[rws_pkg::IFR_LIN_INTERRUPT_FLAG] && system_wake)
    else $error("stop mode LIN wake missed");
  lin_sleep_a: assert property ((lin_evt && sleep_mode && !por_s)
      |=> reset_source_status[rws_pkg::RSR_LINW] ##1 rst_pin_oe)
    else $error("sleep mode LIN wake missed");
  l0_wake_a: assert property ((l0_evt && sleep_mode && !por_s) |=> reset_source_status[rws_pkg::RSR_L0W])
    else $error("L0 wake not flagged");
  lp_tx_a: assert property (lp |=> !lin_tx_enable && !lin_pullup_enable)
    else $error("transmitter left on in low power");

  ot_reset_c: cover property (ot_cause ##1 rst_pin_oe);
  sleep_wake_c: cover property (lin_evt && sleep_mode);
  ext_reset_c: cover property (ext_low);
  rsr_read_c: cover property (rd_wait && hit(a_idx, rws_pkg::IDX_RSR));

endmodule // rws_reset_wake
`default_nettype wire

// ==== include/rws_pkg.sv ====
// Constants and types of the reset and wake-up source block.
// Assumes a 10 MHz bus clock; register indices map to byte address index*4.
`default_nettype none
package rws_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_NS           = 100;
  localparam int RST_PULSE_NS     = 1250000;
  localparam int RST_PULSE_CYC    = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_FILTER_NS   = 100000;
  localparam int WAKE_FILTER_CYC  = (WAKE_FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CNT_W        = 14;
  localparam int WAKE_CNT_W       = 10;

  // ==========================================================================
  // Register indices (byte address is index times four)
  localparam logic [5:0] IDX_IMR  = 6'h09;
  localparam logic [5:0] IDX_IFR  = 6'h0A;
  localparam logic [5:0] IDX_RSR  = 6'h0D;

  // ==========================================================================
  // Reset source status fields
  localparam int RSR_POR          = 7;
  localparam int RSR_PIN          = 6;
  localparam int RSR_WD           = 5;
  localparam int RSR_OT           = 4;
  localparam int RSR_LV           = 3;
  localparam int RSR_LINW         = 1;
  localparam int RSR_L0W          = 0;
  localparam logic [7:0] RSR_POR_VAL = 8'h80;
  localparam logic [7:0] RSR_W1C     = 8'hFB;

  // ==========================================================================
  // Interrupt mask and flag fields (same layout)
  localparam int IMR_L0IE         = 7;
  localparam int IMR_LIN_INTERRUPT_ENABLE        = 5;
  localparam int IMR_OTRD         = 4;
  localparam logic [7:0] IMR_WMASK   = 8'hB0;
  localparam logic [7:0] IMR_RST_VAL = 8'h00;
  localparam int IFR_L0IF         = 7;
  localparam int IFR_LIN_INTERRUPT_FLAG        = 5;
  localparam logic [7:0] IFR_MASK    = 8'hA0;
  localparam logic [7:0] IFR_RST_VAL = 8'h00;

  // ==========================================================================
  // Synchroniser order {ot, lv, por, pin, lin_rx, l0} and idle levels
  localparam int NSYNC            = 6;
  localparam logic [5:0] SYNC_RST_VAL = 6'h06;

  // LIN wake filter states, Gray along the usual path
  typedef enum logic [1:0]
  {
    WF_IDLE  = 2'b00,
    WF_DOM   = 2'b01,
    WF_ARMED = 2'b11
  } rws_wf_t;
endpackage
`default_nettype wire

// ==== verif/rws_far_side.sv ====
// Far side of the block: the LIN bus wire and the shared reset pin.
// Assumes the bench commands bus dominance and outside pulls on the pin.
`timescale 1ns/1ps
`default_nettype none
module rws_far_side (
  // Commands from the bench
  input  wire logic lin_dominant,
  input  wire logic ext_pull,
  // Reset pin drive of the block
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // Levels seen by the block
  output logic      lin_rx,
  output logic      rst_pin
);
  // ==========================================================================
  // Wire levels
  // Weak source keeps the bus recessive when no node pulls it
  assign lin_rx  = !lin_dominant;
  // Open drain with pull-up, so any party can pull it low
  assign rst_pin = (pin_oe ? pin_out : 1'b1) & !ext_pull;
endmodule // rws_far_side
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench of the reset and wake-up source block.
// Assumes a single 10 MHz clock and a shortened reset pulse count.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================================================
  // Settings and signals
  localparam int          P     = 20;
  localparam int          WF    = rws_pkg::WAKE_FILTER_CYC;
  localparam logic [31:0] A_IMR = {24'h0, rws_pkg::IDX_IMR, 2'b00};
  localparam logic [31:0] A_IFR = {24'h0, rws_pkg::IDX_IFR, 2'b00};
  localparam logic [31:0] A_RSR = {24'h0, rws_pkg::IDX_RSR, 2'b00};
  logic              hclk, hresetn, hsel, hwrite;
  logic [31:0]       haddr, hwdata, rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              ot, lv, po, l0, wd, stp, slp, lin_dom, ext_pull;
  logic [7:0]        exp_rsr [4] = '{8'h20, 8'h28, 8'h38, 8'h80};
  wire logic         hreadyout, hresp, pin_out, pin_oe, regs_rst_n, tx_en, pu_en;
  wire logic         system_wake, irq, lin_rx, rst_pin;
  wire logic [31:0]  hrdata;
  wire logic [4:0]   obs = {irq, pin_oe, regs_rst_n, tx_en, pu_en};
  int                num_errors, num_checks, cycles, wakes, w0;

  // ==========================================================================
  // Design and far side
  rws_reset_wake #(.RST_PULSE_CYC(P)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .overtemp_in(ot),
    .low_voltage_in(lv), .power_on_in(po), .rst_pin_in(rst_pin), .lin_rx_in(lin_rx),
    .l0_in(l0), .watchdog_req(wd), .stop_mode(stp), .sleep_mode(slp),
    .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .regs_rst_n(regs_rst_n),
    .lin_tx_enable(tx_en), .lin_pullup_enable(pu_en), .system_wake(system_wake),
    .irq(irq));
  rws_far_side env_u (.lin_dominant(lin_dom), .ext_pull(ext_pull), .pin_out(pin_out),
    .pin_oe(pin_oe), .lin_rx(lin_rx), .rst_pin(rst_pin));

  // Free-running clock
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Cycle limit and wake pulse counter; a hang must still reach the verdict
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (system_wake === 1'b1)
      wakes <= wakes + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      summarize;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready and read data are taken at the rising edge, before it updates them
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
  endtask

  // One single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsel   <= 1'b1;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
  endtask

  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(nm, rd, exp);
    check("resp", {31'h0, hresp}, 32'h0);
  endtask

  // Registered outputs such as irq follow a register write one edge later
  task automatic look(input string nm, input logic [4:0] m, input logic [4:0] exp);
    @(posedge hclk);
    @(negedge hclk);
    check(nm, {27'h0, obs & m}, {27'h0, exp});
    @(posedge hclk);
  endtask

  // Length of the pin drive, in cycles, must fall in a window
  task automatic pulse_chk(input string nm, input int lo, input int hi);
    int k;
    k = 0;
    @(negedge hclk);
    while (pin_oe === 1'b1 && k < 300)
    begin
      k++;
      @(negedge hclk);
    end
    @(posedge hclk);
    repeat (4) @(posedge hclk);
    check(nm, {31'h0, k >= lo && k <= hi}, 32'h1);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    {ot, lv, po, l0, wd, stp, slp, lin_dom, ext_pull} = '0;
    {num_errors, num_checks, cycles, wakes} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    rchk("status", A_RSR, 32'h80);
    rchk("mask", A_IMR, 32'h0);
    rchk("unmapped", 32'h3C, 32'h0);
    bus(1'b1, A_RSR, 32'h0);
    rchk("status", A_RSR, 32'h80);
    bus(1'b1, A_RSR, 32'h80);
    rchk("status", A_RSR, 32'h0);
    // Watchdog, low voltage, overtemp, power-on; flags pile up until power-on
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, A_IMR, 32'h20);
      {wd, lv, ot, po} <= 4'b1000 >> c;
      repeat (5) @(posedge hclk);
      look("held", 5'b01100, 5'b01000);
      {wd, lv, ot, po} <= 4'h0;
      pulse_chk("pulse", P + 1, P + 5);
      rchk("status", A_RSR, {24'h0, exp_rsr[c]});
      rchk("mask", A_IMR, 32'h0);
    end
    bus(1'b1, A_RSR, 32'h80);
    bus(1'b1, A_IMR, 32'h10);
    rchk("mask", A_IMR, 32'h10);
    ot <= 1'b1;
    repeat (5) @(posedge hclk);
    look("no drive", 5'b01000, 5'b00000);
    ot <= 1'b0;
    rchk("status", A_RSR, 32'h0);
    bus(1'b1, A_IMR, 32'h0);
    ext_pull <= 1'b1;
    repeat (6) @(posedge hclk);
    ext_pull <= 1'b0;
    repeat (10) @(posedge hclk);
    rchk("status", A_RSR, 32'h40);
    bus(1'b1, A_RSR, 32'h40);
    // Stop mode: short dominant ignored, long one flags and interrupts
    w0 = wakes;
    bus(1'b1, A_IMR, 32'h20);
    stp <= 1'b1;
    repeat (3) @(posedge hclk);
    look("lin drive", 5'b00011, 5'b00000);
    lin_dom <= 1'b1;
    repeat (WF / 2) @(posedge hclk);
    lin_dom <= 1'b0;
    repeat (5) @(posedge hclk);
    rchk("flags", A_IFR, 32'h0);
    lin_dom <= 1'b1;
    repeat (WF + 10) @(posedge hclk);
    lin_dom <= 1'b0;
    repeat (5) @(posedge hclk);
    rchk("flags", A_IFR, 32'h20);
    look("irq", 5'b10000, 5'b10000);
    bus(1'b1, A_IMR, 32'h0);
    look("irq", 5'b10000, 5'b00000);
    bus(1'b1, A_IMR, 32'h20);
    look("irq", 5'b10000, 5'b10000);
    bus(1'b1, A_IFR, 32'h20);
    rchk("flags", A_IFR, 32'h0);
    look("irq", 5'b10000, 5'b00000);
    stp <= 1'b0;
    // Sleep mode: LIN then L0 wake through a reset
    slp <= 1'b1;
    lin_dom <= 1'b1;
    repeat (WF + 10) @(posedge hclk);
    lin_dom <= 1'b0;
    repeat (4) @(posedge hclk);
    pulse_chk("wake pulse", P - 4, P + 4);
    rchk("status", A_RSR, 32'h02);
    bus(1'b1, A_RSR, 32'h02);
    l0 <= 1'b1;
    repeat (4) @(posedge hclk);
    pulse_chk("wake pulse", P - 4, P + 4);
    rchk("status", A_RSR, 32'h01);
    slp <= 1'b0;
    check("wakes", wakes - w0, 32'h3);
    summarize;
  end
endmodule // testbench
`default_nettype wire
